// File: rtl/dac_latch_pkg.sv
// Purpose: constants shared by the serial dac input latch design
// Assumes: 100 MHz system clock, serial link sampled as ordinary inputs
// Notes: variant and resolution are strap inputs of the top module
//
// Operation
// - After frame select falls, each rising serial clock edge shifts one data bit in, most significant first.
// - A rising edge of frame select copies the shift register into the 16-bit dac latch at once (here only after 16 or more edges, queued in the word fifo first).
// - While frame select is high, serial clock edges are ignored and the shift register holds.
// - With more than 16 edges in a frame, only the last 16 bits shifted in reach the latch.
// - A 14-bit code is left-justified with two ignored filler bits below its least significant bit.
// - A 12-bit code is left-justified with four ignored filler bits below its least significant bit.
// - At power-up the unipolar variant sets the latch to code zero.
// - At power-up the bipolar variant sets the latch to midscale for its resolution (here 16'h2000 at 14 bits and 16'h0800 at 12 bits, right-justified values).
// - A low level on the clear input, independent of the serial clock, resets the latch to its clear value.
// - In unipolar use the latch holds a straight binary code.
// - In bipolar use the latch holds an offset binary code, midscale being zero volts.
// - The four top code bits decode to 15 equal thermometer segment enables; lower bits drive binary sections.
package dac_latch_pkg;

  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam int SEG_BITS = 4;
  localparam int SEG_COUNT = 15;
  localparam int BIN_BITS = WORD_BITS - SEG_BITS;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // reset and clear codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] MID_16 = 16'h8000;
  localparam logic [15:0] MID_14 = 16'h2000;
  localparam logic [15:0] MID_12 = 16'h0800;

  // ----------------------------------------------------------------
  // resolution and filler masks
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RES_16, RES_14, RES_12} res_t;
  localparam logic [15:0] MASK_16 = 16'hffff;
  localparam logic [15:0] MASK_14 = 16'hfffc;
  localparam logic [15:0] MASK_12 = 16'hfff0;

endpackage

// File: rtl/word_fifo.sv
// Purpose: small valid/ready fifo
// Assumes: one clock, asynchronous active-low reset
// Notes: full and empty come from a count, so all slots are usable
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (st.count != (AW+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data = mem[st.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // storage carries no reset; contents only matter once counted
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st.wr] <= in_data;
    end
  end

endmodule
`default_nettype wire

// File: rtl/serial_dac_input_latch.sv
// Purpose: serial front end and dac latch of a 16/14/12-bit voltage dac
// Assumes: link pins are asynchronous and sampled by clk; link bit rate well below clk/4
// Notes: completed words queue in a fifo before the latch; analog ladder not modelled
`timescale 1ns/10ps
`default_nettype none
module serial_dac_input_latch
  import dac_latch_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // straps
  input wire logic bipolar_variant,
  input wire logic [1:0] resolution,
  // serial link
  input wire logic frame_sel_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  // asynchronous clear
  input wire logic async_clear_n,
  // converter drive
  output logic [15:0] dac_code,
  output logic [dac_latch_pkg::SEG_COUNT-1:0] segment_en,
  output logic [dac_latch_pkg::BIN_BITS-1:0] binary_bits,
  output logic dac_update,
  output logic frame_dropped
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] mid_code(input logic [1:0] res);
    unique case (res_t'(res))
      RES_14: mid_code = MID_14;
      RES_12: mid_code = MID_12;
      default: mid_code = MID_16;
    endcase
  endfunction

  function automatic logic [15:0] res_mask(input logic [1:0] res);
    unique case (res_t'(res))
      RES_14: res_mask = MASK_14;
      RES_12: res_mask = MASK_12;
      default: res_mask = MASK_16;
    endcase
  endfunction

  // thermometer: segment i on when the top nibble exceeds i
  function automatic logic [SEG_COUNT-1:0] thermo(input logic [SEG_BITS-1:0] top);
    logic [SEG_COUNT-1:0] t;
    t = '0;
    for (int i = 0; i < SEG_COUNT; i++) begin
      t[i] = (top > SEG_BITS'(i));
    end
    thermo = t;
  endfunction

  function automatic logic [15:0] clear_code(input logic bip, input logic [1:0] res);
    clear_code = bip ? mid_code(res) : CODE_ZERO;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {POR_LOAD, RUN} phase_t;

  typedef struct packed {
    logic [2:0] fs_sync;
    logic [2:0] sck_sync;
    logic [1:0] din_sync;
    logic [1:0] clr_sync;
    logic [15:0] shift;
    logic [4:0] bit_count;
    logic [15:0] latch;
    logic [SEG_COUNT-1:0] seg;
    logic [BIN_BITS-1:0] bin;
    logic update;
    logic dropped;
    phase_t phase;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  logic fs_low;
  logic fs_rise;
  logic sck_rise;
  logic clr_low;
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic pop_ready;
  logic [15:0] pop_data;
  logic [15:0] cur_clear;
  logic [15:0] new_code;

  // ----------------------------------------------------------------
  // synchronised link view
  // ----------------------------------------------------------------
  // stage [0] only feeds stage [1]; edges are found on stages [1] and [2]
  assign fs_low = !st.fs_sync[1];
  assign fs_rise = st.fs_sync[1] && !st.fs_sync[2];
  assign sck_rise = st.sck_sync[1] && !st.sck_sync[2];
  assign clr_low = !st.clr_sync[1];
  assign cur_clear = clear_code(bipolar_variant, resolution);

  // a word is offered on every frame end that saw a full word while clear is not low
  assign push_valid = fs_rise && (st.bit_count >= 5'(WORD_BITS)) && !clr_low;
  assign pop_ready = (st.phase == RUN) && !clr_low;

  word_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_word_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_data(st.shift),
    .in_ready(push_ready),
    .out_valid(pop_valid),
    .out_data(pop_data),
    .out_ready(pop_ready)
  );

  // filler bits below the code are ignored
  assign new_code = pop_data & res_mask(resolution);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.fs_sync = {st.fs_sync[1:0], frame_sel_n};
    next_st.sck_sync = {st.sck_sync[1:0], ser_clk};
    next_st.din_sync = {st.din_sync[0], ser_data};
    next_st.clr_sync = {st.clr_sync[0], async_clear_n};
    next_st.update = 1'b0;
    next_st.dropped = 1'b0;

    // shift only inside a frame; a frame end restarts the count
    if (fs_low && sck_rise) begin
      next_st.shift = {st.shift[14:0], st.din_sync[1]};
      if (st.bit_count < 5'(WORD_BITS)) begin
        next_st.bit_count = st.bit_count + 5'd1;
      end
    end
    if (fs_rise) begin
      next_st.bit_count = '0;
      // short frames and a full queue both lose the word
      if ((st.bit_count < 5'(WORD_BITS)) || !push_ready) begin
        next_st.dropped = 1'b1;
      end
    end

    unique case (st.phase)
      POR_LOAD: begin
        next_st.latch = cur_clear;
        next_st.update = 1'b1;
        next_st.phase = RUN;
      end
      RUN: begin
        if (clr_low) begin
          next_st.latch = cur_clear;
        end else if (pop_valid) begin
          next_st.latch = new_code;
          next_st.update = 1'b1;
        end
      end
      default: next_st.phase = POR_LOAD;
    endcase

    // latch code drives the ladder as is: straight or offset binary
    next_st.seg = thermo(next_st.latch[15:BIN_BITS]);
    next_st.bin = next_st.latch[BIN_BITS-1:0];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{fs_sync: 3'b111, sck_sync: 3'b000, din_sync: 2'b00, clr_sync: 2'b11,
              shift: CODE_ZERO, bit_count: 5'd0, latch: CODE_ZERO, seg: '0, bin: '0,
              update: 1'b0, dropped: 1'b0, phase: POR_LOAD};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dac_code = st.latch;
  assign segment_en = st.seg;
  assign binary_bits = st.bin;
  assign dac_update = st.update;
  assign frame_dropped = st.dropped;

endmodule
`default_nettype wire

// File: tb/dac_latch_properties.sv
// Purpose: port checker for the serial dac input latch
// Assumes: straps change only while reset is held
// Notes: clear value worked out here from the straps
`timescale 1ns/10ps
`default_nettype none
module dac_latch_properties
  import dac_latch_pkg::*;
(
  // clock, reset, straps
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bipolar_variant,
  input wire logic [1:0] resolution,
  // link and clear
  input wire logic frame_sel_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic async_clear_n,
  // converter drive
  input wire logic [15:0] dac_code,
  input wire logic [dac_latch_pkg::SEG_COUNT-1:0] segment_en,
  input wire logic [dac_latch_pkg::BIN_BITS-1:0] binary_bits,
  input wire logic dac_update,
  input wire logic frame_dropped
);
  logic [15:0] clr;
  assign clr = !bipolar_variant ? CODE_ZERO : resolution == 2'd1 ? MID_14 : resolution == 2'd2 ? MID_12 : MID_16;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_por;
    $rose(rst_n) |=> dac_update && dac_code == clr;
  endproperty
  a_por: assert property (p_por) else $error("power-on code wrong");
  property p_bin;
    binary_bits == dac_code[11:0];
  endproperty
  a_bin: assert property (p_bin) else $error("binary bits differ from code");
  property p_seg;
    segment_en == 15'(15'h7fff >> (4'd15 - dac_code[15:12]));
  endproperty
  a_seg: assert property (p_seg) else $error("segment decode wrong");
  property p_fill14;
    resolution == 2'd1 |-> dac_code[1:0] == 2'b00;
  endproperty
  a_fill14: assert property (p_fill14) else $error("14-bit filler reached latch");
  property p_fill12;
    resolution == 2'd2 |-> dac_code[3:0] == 4'h0;
  endproperty
  a_fill12: assert property (p_fill12) else $error("12-bit filler reached latch");
  property p_clear;
    !async_clear_n [*6] |-> dac_code == clr;
  endproperty
  a_clear: assert property (p_clear) else $error("clear value not held");
  property p_clr_hold;
    !async_clear_n [*6] |-> !dac_update;
  endproperty
  a_clr_hold: assert property (p_clr_hold) else $error("load during clear");
  property p_idle;
    frame_sel_n [*8] |-> !dac_update;
  endproperty
  a_idle: assert property (p_idle) else $error("update without frame end");
  property p_drop;
    frame_dropped |=> !frame_dropped;
  endproperty
  a_drop: assert property (p_drop) else $error("drop pulse too long");
endmodule
bind serial_dac_input_latch dac_latch_properties dac_latch_properties_inst (.*);
`default_nettype wire

// File: tb/spi_host_model.sv
// Purpose: host side of the serial link
// Assumes: 160 ns link clock, idle low between frames
// Notes: sel low sends clock edges with frame select left high
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // serial link
  output logic frame_sel_n,
  output logic ser_clk,
  output logic ser_data
);
  initial begin
    frame_sel_n = 1'b1;
    ser_clk = 1'b0;
    ser_data = 1'b0;
  end
  // data moves while the clock is low, far from each rising edge
  task automatic send(input logic [31:0] bits, input int n, input logic sel);
    frame_sel_n = !sel;
    #80;
    for (int i = n - 1; i >= 0; i--) begin
      ser_data = bits[i];
      #80 ser_clk = 1'b1;
      #80 ser_clk = 1'b0;
    end
    #80 frame_sel_n = 1'b1;
    ser_data = !ser_data;
    #80;
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Purpose: self-checking bench for the serial dac input latch
// Assumes: straps change only under reset
// Notes: pulses are counted so none is missed while a frame runs
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dac_latch_pkg::*;
  typedef struct {logic bip; logic [1:0] res; logic [31:0] bits; int n; logic [15:0] code; logic drop;} row_t;
  logic clk, rst_n, bipolar_variant, async_clear_n, dac_update, frame_dropped;
  logic [1:0] resolution;
  logic [15:0] dac_code;
  logic [SEG_COUNT-1:0] segment_en;
  logic [BIN_BITS-1:0] binary_bits;
  wire logic frame_sel_n, ser_clk, ser_data;
  int n_fail = 0, cmp_count = 0, cyc = 0, n_upd = 0, n_drop = 0, u, d;
  row_t rows [7] = '{'{1'b0, 2'd0, 32'h0000_a5c3, 16, 16'ha5c3, 1'b0},
    '{1'b0, 2'd0, 32'h000f_1234, 20, 16'h1234, 1'b0}, '{1'b0, 2'd0, 32'h0000_00ff, 8, 16'h1234, 1'b1},
    '{1'b1, 2'd0, 32'h0000_0001, 16, 16'h0001, 1'b0}, '{1'b1, 2'd1, 32'h0000_ffff, 16, 16'hfffc, 1'b0},
    '{1'b1, 2'd3, 32'h0000_ffff, 16, 16'hffff, 1'b0}, '{1'b1, 2'd2, 32'h0000_8abc, 16, 16'h8ab0, 1'b0}};
  // short frame sent after idle edges: a count that leaked from them would accept it
  row_t short_row = '{1'b1, 2'd2, 32'h0000_00a5, 8, 16'h8ab0, 1'b1};
  serial_dac_input_latch serial_dac_input_latch_inst (.clk(clk), .rst_n(rst_n), .bipolar_variant(bipolar_variant),
    .resolution(resolution), .frame_sel_n(frame_sel_n), .ser_clk(ser_clk), .ser_data(ser_data),
    .async_clear_n(async_clear_n), .dac_code(dac_code), .segment_en(segment_en), .binary_bits(binary_bits),
    .dac_update(dac_update), .frame_dropped(frame_dropped));
  spi_host_model spi_host_model_inst (.frame_sel_n(frame_sel_n), .ser_clk(ser_clk), .ser_data(ser_data));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // the ceiling is roughly seven times the expected run of about 2700 cycles
  always @(posedge clk) begin
    cyc++;
    if (dac_update === 1'b1) n_upd++;
    if (frame_dropped === 1'b1) n_drop++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] clr_code(input logic bip, input logic [1:0] res);
    return !bip ? CODE_ZERO : res == 2'd1 ? MID_14 : res == 2'd2 ? MID_12 : MID_16;
  endfunction
  task automatic check_out(input logic [15:0] exp);
    @(negedge clk);
    chk("dac_code", exp, dac_code);
    chk("segment_en", 16'(15'h7fff >> (4'd15 - exp[15:12])), 16'(segment_en));
    chk("binary_bits", 16'(exp[11:0]), 16'(binary_bits));
  endtask
  task automatic do_reset(input logic bip, input logic [1:0] res);
    @(posedge clk);
    rst_n <= 1'b0;
    bipolar_variant <= bip;
    resolution <= res;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic frame(input row_t r);
    u = n_upd;
    d = n_drop;
    spi_host_model_inst.send(r.bits, r.n, 1'b1);
    for (int i = 0; i < 20 && n_upd == u && n_drop == d; i++) @(posedge clk);
    chk("frame_dropped", 16'(r.drop), 16'(n_drop != d));
    check_out(r.code);
  endtask
  initial begin
    rst_n = 1'b0;
    bipolar_variant = 1'b0;
    resolution = 2'd0;
    async_clear_n = 1'b1;
    do_reset(1'b0, 2'd0);
    check_out(CODE_ZERO);
    $display("reset test done");
    for (int k = 0; k < 7; k++) begin
      if (rows[k].bip !== bipolar_variant || rows[k].res !== resolution) begin
        do_reset(rows[k].bip, rows[k].res);
        check_out(clr_code(rows[k].bip, rows[k].res));
      end
      frame(rows[k]);
      $display("row %0d done", k);
    end
    u = n_upd;
    spi_host_model_inst.send(32'h0000_5555, 16, 1'b0);
    repeat (20) @(posedge clk);
    chk("update count", 16'h0000, 16'(n_upd - u));
    check_out(16'h8ab0);
    frame(short_row);
    $display("idle clock test done");
    @(posedge clk);
    async_clear_n <= 1'b0;
    repeat (6) @(posedge clk);
    check_out(MID_12);
    spi_host_model_inst.send(32'h0000_1111, 16, 1'b1);
    check_out(MID_12);
    @(posedge clk);
    async_clear_n <= 1'b1;
    repeat (10) @(posedge clk);
    check_out(MID_12);
    $display("clear test done");
    stop_test();
  end
endmodule
`default_nettype wire
